// ==== core/eac_params.svh ====
`ifndef EAC_PARAMS_SVH
`define EAC_PARAMS_SVH

// System clock and the calibrated programming oscillator
`define EAC_CLK_HZ       50000000
`define EAC_OSC_HZ       1000000
`define EAC_OSC_DIV      (`EAC_CLK_HZ / `EAC_OSC_HZ)
`define EAC_PROG_CYCLES  8448
`define EAC_DEPTH        512

// Cycle counts in system clocks
`define EAC_MWE_HOLD     3'h4
`define EAC_WR_STALL     3'h2
`define EAC_RD_STALL     3'h4

// Control register bit positions
`define EAC_B_RIE        3
`define EAC_B_MWE        2
`define EAC_B_WE         1
`define EAC_B_RE         0

// Register select on the I/O port
`define EAC_SEL_CTRL     2'h0
`define EAC_SEL_ADDR     2'h1
`define EAC_SEL_DATA     2'h2

// Host registers on AXI4-Lite (byte addresses)
`define EAC_A_CMD        8'h00
`define EAC_A_STAT       8'h04
`define EAC_A_DATA       8'h08
`define EAC_A_ISTAT      8'h0C
`define EAC_A_ICLR       8'h10
`define EAC_A_IEN        8'h14
`define EAC_A_CFG        8'h18

// Command word fields
`define EAC_CMD_SEQ      11
`define EAC_CMD_SEL_HI   10
`define EAC_CMD_SEL_LO   9

// Interrupt status bits
`define EAC_I_WDONE      0
`define EAC_I_READY      1

`define EAC_RESP_OKAY    2'h0
`define EAC_RESP_SLVERR  2'h2

`endif

// ==== core/eac_pkg.sv ====
`include "eac_params.svh"

package eac_pkg;

  typedef enum logic [1:0] {
    EAC_H_IDLE,
    EAC_H_WAIT,
    EAC_H_MWE
  } eac_hst_e;

  typedef struct packed {
    logic        rie;
    logic        mwe;
    logic        we;
    logic [2:0]  mwe_cnt;
    logic [8:0]  addr;
    logic [7:0]  data;
    logic [7:0]  wr_byte;
    logic [2:0]  stall_cnt;
    logic        stall;
    logic [5:0]  div_cnt;
    logic [13:0] tick_cnt;
    logic        irq;
  } eac_dev_s;

  typedef struct packed {
    logic [7:0]  awaddr;
    logic        aw_got;
    logic [31:0] wdata;
    logic        w_got;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        pend;
    logic [11:0] cmd;
    eac_hst_e    st;
    logic        wr;
    logic [1:0]  sel;
    logic [8:0]  wdat;
    logic        gie;
    logic        flash;
    logic [1:0]  istat;
    logic [1:0]  ien;
    logic        irq;
    logic        prev_we;
    logic        prev_rdy;
  } eac_host_s;

endpackage : eac_pkg

// ==== core/eac_io_if.sv ====
`timescale 1ns/100ps
`default_nettype none

interface eac_io_if;
  logic       wr;
  logic [1:0] sel;
  logic [8:0] wdata;
  logic       gie;
  logic       flash_busy;
  logic [7:0] ctrl;
  logic [8:0] addr;
  logic [7:0] data;
  logic       stall;
  logic       ready_irq;

  modport dev (
    input  wr, sel, wdata, gie, flash_busy,
    output ctrl, addr, data, stall, ready_irq
  );

  modport cpu (
    output wr, sel, wdata, gie, flash_busy,
    input  ctrl, addr, data, stall, ready_irq
  );
endinterface : eac_io_if

`default_nettype wire

// ==== core/eac_dev.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "eac_params.svh"

////////////////////////////////////////////////////////////////////////////////
module eac_dev
  import eac_pkg::*;
#(
  parameter int PROG_TICKS = `EAC_PROG_CYCLES,
  parameter int OSC_DIV    = `EAC_OSC_DIV,
  parameter int DEPTH      = `EAC_DEPTH
) (
  input  wire logic core_clk,
  input  wire logic arst_n,
  eac_io_if.dev     io,
  output logic      prog_active
);

  eac_dev_s   q;
  eac_dev_s   next_q;
  logic [7:0] mem [0:DEPTH-1];
  logic       tick;
  logic       prog_done;
  logic       start_wr;
  logic       start_rd;
  logic       ctrl_wr;

  //////////////////////////////////////////////////////////////////////////////
  // Strobes decoded from the I/O write port

  always_comb begin
    ctrl_wr   = io.wr && (io.sel == `EAC_SEL_CTRL);
    // The strobe is only honoured while the master enable still stands
    start_wr  = ctrl_wr && io.wdata[`EAC_B_WE] && q.mwe && !q.we
                && !io.flash_busy;
    // A read during programming would see a half-written cell
    start_rd  = ctrl_wr && io.wdata[`EAC_B_RE] && !q.we;
    // One-cycle enable stands in for the 1 MHz oscillator edge
    tick      = (q.div_cnt == 6'(OSC_DIV - 1));
    prog_done = q.we && tick && (q.tick_cnt == 14'(PROG_TICKS - 1));
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_q = q;

    if (tick) begin
      next_q.div_cnt = 6'h00;
    end else begin
      next_q.div_cnt = q.div_cnt + 6'h01;
    end

    // Timeout of the master enable
    if (q.mwe) begin
      next_q.mwe_cnt = q.mwe_cnt - 3'h1;
      if (q.mwe_cnt == 3'h1) begin
        next_q.mwe = 1'b0;
      end
    end

    if (q.stall_cnt != 3'h0) begin
      next_q.stall_cnt = q.stall_cnt - 3'h1;
    end

    // Programming timer counts oscillator ticks only
    if (q.we && tick) begin
      next_q.tick_cnt = q.tick_cnt + 14'h0001;
    end
    if (prog_done) begin
      next_q.we = 1'b0;
    end

    if (io.wr) begin
      case (io.sel)
        `EAC_SEL_CTRL: begin
          next_q.rie = io.wdata[`EAC_B_RIE];
          next_q.mwe = io.wdata[`EAC_B_MWE];
          if (io.wdata[`EAC_B_MWE]) begin
            next_q.mwe_cnt = `EAC_MWE_HOLD;
          end
          if (start_wr) begin
            next_q.we        = 1'b1;
            next_q.tick_cnt  = 14'h0000;
            next_q.wr_byte   = q.data;
            next_q.stall_cnt = `EAC_WR_STALL;
          end else if (start_rd) begin
            next_q.data      = mem[q.addr];
            next_q.stall_cnt = `EAC_RD_STALL;
          end
        end
        `EAC_SEL_ADDR: begin
          if (!q.we) begin
            next_q.addr = io.wdata;
          end
        end
        `EAC_SEL_DATA: begin
          next_q.data = io.wdata[7:0];
        end
        default: begin
          next_q.data = q.data;
        end
      endcase
    end

    next_q.stall = (next_q.stall_cnt != 3'h0);
    next_q.irq   = next_q.rie && io.gie && !next_q.we;
  end

  //////////////////////////////////////////////////////////////////////////////
  // State registers

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  // Cell array has no reset; its content is nonvolatile in spirit
  always_ff @(posedge core_clk) begin
    if (prog_done) begin
      mem[q.addr] <= q.wr_byte;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign io.ctrl      = {4'h0, q.rie, q.mwe, q.we, 1'b0};
  assign io.addr      = q.addr;
  assign io.data      = q.data;
  assign io.stall     = q.stall;
  assign io.ready_irq = q.irq;
  assign prog_active  = q.we;

endmodule : eac_dev

`default_nettype wire

// ==== core/eac_host.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "eac_params.svh"

module eac_host
  import eac_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        flash_selfprog_enable,
  output logic             irq,
  eac_io_if.cpu            io
);

  eac_host_s  q;
  eac_host_s  next_q;
  logic [1:0] ev;

  //////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_q    = q;
    next_q.wr = 1'b0;
    next_q.flash = flash_selfprog_enable;

    // AXI write channels, taken in either order
    if (s_axi_awvalid && q.awready) begin
      next_q.awaddr = s_axi_awaddr;
      next_q.aw_got = 1'b1;
    end
    if (s_axi_wvalid && q.wready) begin
      next_q.wdata = s_axi_wdata;
      next_q.w_got = 1'b1;
    end
    if (q.bvalid && s_axi_bready) begin
      next_q.bvalid = 1'b0;
    end

    if (q.aw_got && q.w_got && !q.bvalid) begin
      next_q.bresp = `EAC_RESP_OKAY;
      case (q.awaddr)
        `EAC_A_CMD: begin
          // A full command slot stalls the response, not the data
          if (!q.pend && (s_axi_wstrb != 4'h0)) begin
            next_q.pend = 1'b1;
            next_q.cmd  = q.wdata[11:0];
          end
        end
        `EAC_A_ICLR: next_q.istat = q.istat & ~q.wdata[1:0];
        `EAC_A_IEN:  next_q.ien   = q.wdata[1:0];
        `EAC_A_CFG:  next_q.gie   = q.wdata[0];
        default:     next_q.bresp = `EAC_RESP_SLVERR;
      endcase
      if (q.awaddr != `EAC_A_CMD || q.pend == 1'b0) begin
        next_q.aw_got = 1'b0;
        next_q.w_got  = 1'b0;
        next_q.bvalid = 1'b1;
      end
    end

    // AXI read channel
    if (q.rvalid && s_axi_rready) begin
      next_q.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      next_q.rvalid = 1'b1;
      next_q.rresp  = `EAC_RESP_OKAY;
      case (s_axi_araddr)
        // Pending holds until the device has taken the issued write
        `EAC_A_STAT:  next_q.rdata = {21'h0, io.ready_irq, (q.pend | q.wr), io.stall, io.ctrl};
        `EAC_A_DATA:  next_q.rdata = {7'h0, io.addr, 8'h00, io.data};
        `EAC_A_ISTAT: next_q.rdata = {30'h0, q.istat};
        `EAC_A_IEN:   next_q.rdata = {30'h0, q.ien};
        `EAC_A_CFG:   next_q.rdata = {31'h0, q.gie};
        `EAC_A_CMD,
        `EAC_A_ICLR:  next_q.rdata = 32'h0000_0000;
        default: begin
          next_q.rdata = 32'h0000_0000;
          next_q.rresp = `EAC_RESP_SLVERR;
        end
      endcase
    end

    // Command issue toward the device; honour stall and last issue, except the strobe in EAC_H_MWE right after the enable
    case (q.st)
      EAC_H_IDLE: begin
        if (q.pend && !io.stall && !q.wr) begin
          if (q.cmd[`EAC_CMD_SEQ]) begin
            next_q.st = EAC_H_WAIT;
          end else begin
            next_q.wr    = 1'b1;
            next_q.sel   = q.cmd[`EAC_CMD_SEL_HI:`EAC_CMD_SEL_LO];
            next_q.wdat  = q.cmd[8:0];
            next_q.pend  = 1'b0;
          end
        end
      end
      EAC_H_WAIT: begin
        // Previous write and flash programming must both be over
        if (!io.ctrl[`EAC_B_WE] && !q.flash && !io.stall) begin
          next_q.wr   = 1'b1;
          next_q.sel  = `EAC_SEL_CTRL;
          next_q.wdat = 9'h000;
          next_q.wdat[`EAC_B_RIE] = io.ctrl[`EAC_B_RIE];
          next_q.wdat[`EAC_B_MWE] = 1'b1;
          next_q.st   = EAC_H_MWE;
        end
      end
      EAC_H_MWE: begin
        // Strobe follows the enable in the next cycle, well inside the window
        next_q.wr   = 1'b1;
        next_q.wdat[`EAC_B_WE] = 1'b1;
        next_q.pend = 1'b0;
        next_q.st   = EAC_H_IDLE;
      end
      default: begin
        next_q.st = EAC_H_IDLE;
      end
    endcase

    // Sticky events; a new event beats a clear in the same cycle
    ev = 2'b00;
    ev[`EAC_I_WDONE] = q.prev_we && !io.ctrl[`EAC_B_WE];
    ev[`EAC_I_READY] = io.ready_irq && !q.prev_rdy;
    next_q.istat    = next_q.istat | ev;
    next_q.prev_we  = io.ctrl[`EAC_B_WE];
    next_q.prev_rdy = io.ready_irq;
    next_q.irq      = |(next_q.istat & next_q.ien);

    next_q.awready = !next_q.aw_got && !next_q.bvalid;
    next_q.wready  = !next_q.w_got && !next_q.bvalid;
    next_q.arready = !next_q.rvalid;
  end

  //////////////////////////////////////////////////////////////////////////////
  // State registers

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign s_axi_awready = q.awready;
  assign s_axi_wready  = q.wready;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;
  assign irq           = q.irq;
  assign io.wr         = q.wr;
  assign io.sel        = q.sel;
  assign io.wdata      = q.wdat;
  assign io.gie        = q.gie;
  assign io.flash_busy = q.flash;

endmodule : eac_host

`default_nettype wire

// ==== dv/eac_io_sva.sv ====
`timescale 1ns/100ps
`default_nettype none

module eac_io_sva #(
  parameter int PROG_TICKS = 8448,
  parameter int OSC_DIV    = 50
) (
  input wire logic       core_clk,
  input wire logic       arst_n,
  input wire logic       wr,
  input wire logic [1:0] sel,
  input wire logic [8:0] wdata,
  input wire logic       gie,
  input wire logic       flash_busy,
  input wire logic [7:0] ctrl,
  input wire logic [8:0] addr,
  input wire logic [7:0] data,
  input wire logic       stall,
  input wire logic       ready_irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  logic [19:0] wcnt;
  logic        go_wr;
  logic        go_rd;

  assign go_wr = wr && sel == 2'h0 && wdata[1] && ctrl[2] && !ctrl[1] && !flash_busy;
  assign go_rd = wr && sel == 2'h0 && wdata[1:0] == 2'h1 && !ctrl[1];

  // Length of the strobe, so the programming time can be bounded by parameters
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) wcnt <= 20'h0;
    else if (ctrl[1]) wcnt <= wcnt + 20'h1;
    else wcnt <= 20'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  a_rsvd_zero: assert property (ctrl[7:4] == 4'h0 && !ctrl[0])
    else $error("reserved or read strobe bits read nonzero");
  // Enable and strobe are seen in the same cycle; the global bit lags by one
  a_ready_irq: assert property (ready_irq == (ctrl[3] && !ctrl[1] && $past(gie)))
    else $error("ready interrupt level wrong");
  a_mwe_timeout: assert property ($rose(ctrl[2]) |-> ctrl[2][*4] ##[1:2] !ctrl[2])
    else $error("master enable did not time out");
  a_strobe_gate: assert property ($rose(ctrl[1]) |-> $past(ctrl[2] && !flash_busy))
    else $error("write started without enable");
  a_strobe_start: assert property (go_wr |=> ctrl[1])
    else $error("enabled strobe did not start write");
  a_wr_stall: assert property ($rose(ctrl[1]) |-> stall[*2] ##1 !stall)
    else $error("write stall length wrong");
  a_rd_stall: assert property (go_rd |=> stall[*4] ##1 !stall)
    else $error("read stall length wrong");
  a_addr_frozen: assert property (ctrl[1] |=> $stable(addr))
    else $error("address changed during write");
  a_rd_blocked: assert property (ctrl[1] && wr && sel == 2'h0 && wdata[0] |=> $stable(data))
    else $error("read taken during write");
  a_prog_time: assert property ($fell(ctrl[1]) |->
      wcnt >= (PROG_TICKS - 1) * OSC_DIV && wcnt <= (PROG_TICKS + 1) * OSC_DIV)
    else $error("programming time out of range");

  c_wr_done: cover property ($fell(ctrl[1]));
  c_rd: cover property (go_rd);
  c_irq: cover property ($rose(ready_irq));
  c_flash: cover property (flash_busy && wr);
endmodule : eac_io_sva

`default_nettype wire

// ==== dv/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "eac_params.svh"

module tb_top;
  logic        core_clk, arst_n, flash;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdat, rdata, rd;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, irq, prog;
  logic [1:0]  bresp, rresp, rsp;
  logic [8:0]  a;
  logic [7:0]  d;
  logic [7:0]  mem [int];
  int          fails, n_compared, seed, cyc;

  eac_io_if io ();
  eac_host eac_host_i (.core_clk(core_clk), .arst_n(arst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdat),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .flash_selfprog_enable(flash), .irq(irq), .io(io));
  // Short programming time keeps the run small
  eac_dev #(.PROG_TICKS(4), .OSC_DIV(8)) eac_dev_i (.core_clk(core_clk),
    .arst_n(arst_n), .io(io), .prog_active(prog));
  eac_io_sva #(.PROG_TICKS(4), .OSC_DIV(8)) eac_io_sva_i (.core_clk(core_clk),
    .arst_n(arst_n), .wr(io.wr), .sel(io.sel), .wdata(io.wdata), .gie(io.gie),
    .flash_busy(io.flash_busy), .ctrl(io.ctrl), .addr(io.addr), .data(io.data),
    .stall(io.stall), .ready_irq(io.ready_irq));

  always #10 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] ad, input logic [31:0] dt);
    awaddr <= ad;
    wdat <= dt;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    // Ready stays high; lowering it would clash with a following call
    rsp = bresp;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] ad);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    rsp = rresp;
  endtask : axi_rd

  function automatic logic [31:0] cw(input logic [1:0] s, input logic [8:0] v);
    return {21'h0, s, v};
  endfunction : cw

  task automatic wait_idle;
    do axi_rd(`EAC_A_STAT); while (rd[1] || rd[9]);
  endtask : wait_idle

  task automatic setup(input logic [8:0] ad, input logic [7:0] dt);
    // Odd addresses load the data first; the order must not matter
    if (ad[0]) axi_wr(`EAC_A_CMD, cw(2'h2, {1'b0, dt}));
    axi_wr(`EAC_A_CMD, cw(2'h1, ad));
    if (!ad[0]) axi_wr(`EAC_A_CMD, cw(2'h2, {1'b0, dt}));
  endtask : setup

  task automatic ee_rd(input logic [8:0] ad);
    wait_idle();
    axi_wr(`EAC_A_CMD, cw(2'h1, ad));
    axi_wr(`EAC_A_CMD, cw(2'h0, 9'h001));
    // The read command must reach the device before the data is fetched
    wait_idle();
    axi_rd(`EAC_A_DATA);
    chk("rd data", {24'h0, rd[7:0]}, {24'h0, mem[ad]});
    chk("rd addr", {23'h0, rd[24:16]}, {23'h0, ad});
  endtask : ee_rd

  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude

  // Every poll loop is unbounded; this ceiling ends a hang
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      conclude();
    end
  end

  initial begin
    {core_clk, arst_n, flash, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdat, fails, n_compared, cyc} = '0;
    seed = 94;
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    axi_rd(`EAC_A_STAT);
    chk("stat", rd, 32'h0);
    axi_rd(8'h1C);
    chk("rresp", rsp, `EAC_RESP_SLVERR);
    axi_wr(`EAC_A_STAT, 32'hF);
    chk("bresp", rsp, `EAC_RESP_SLVERR);
    $display("reset test done");
    for (int i = 0; i < 6; i++) begin
      a = (i == 0) ? 9'h000 : (i == 1) ? 9'h1FF : 9'($random(seed));
      d = 8'($random(seed));
      mem[a] = d;
      setup(a, d);
      axi_wr(`EAC_A_CMD, 32'h800);
      wait_idle();
    end
    foreach (mem[k]) ee_rd(9'(k));
    $display("write read test done");
    axi_wr(`EAC_A_CMD, cw(2'h0, 9'h002));
    repeat (4) @(posedge core_clk);
    axi_rd(`EAC_A_STAT);
    chk("no enable", {24'h0, rd[7:0]}, 32'h0);
    a = 9'h0A5;
    d = 8'h3C;
    setup(a, d);
    flash <= 1'b1;
    axi_wr(`EAC_A_CMD, 32'h800);
    repeat (40) @(posedge core_clk);
    axi_rd(`EAC_A_STAT);
    chk("flash hold", {22'h0, rd[9:0]}, 32'h200);
    chk("prog idle", prog, 1'b0);
    flash <= 1'b0;
    wait_idle();
    mem[a] = d;
    ee_rd(a);
    $display("refusal test done");
    setup(9'h155, 8'hC3);
    axi_wr(`EAC_A_CMD, 32'h800);
    axi_wr(`EAC_A_CMD, cw(2'h1, 9'h0AA));
    chk("prog busy", prog, 1'b1);
    axi_wr(`EAC_A_CMD, cw(2'h0, 9'h001));
    wait_idle();
    axi_rd(`EAC_A_DATA);
    chk("frozen", {rd[24:16], rd[7:0]}, {9'h155, 8'hC3});
    mem[9'h155] = 8'hC3;
    ee_rd(9'h155);
    $display("busy test done");
    axi_wr(`EAC_A_CFG, 32'h1);
    // Old write-done events would otherwise mask the ready check
    axi_wr(`EAC_A_ICLR, 32'h3);
    axi_wr(`EAC_A_IEN, 32'h3);
    axi_wr(`EAC_A_CMD, cw(2'h0, 9'h008));
    repeat (4) @(posedge core_clk);
    chk("irq on", irq, 1'b1);
    axi_wr(`EAC_A_CMD, 32'h800);
    wait_idle();
    repeat (4) @(posedge core_clk);
    axi_rd(`EAC_A_ISTAT);
    chk("istat", rd, 32'h3);
    axi_wr(`EAC_A_IEN, 32'h0);
    repeat (4) @(posedge core_clk);
    chk("irq masked", irq, 1'b0);
    axi_wr(`EAC_A_ICLR, 32'h3);
    axi_rd(`EAC_A_ISTAT);
    chk("cleared", rd, 32'h0);
    $display("interrupt test done");
    conclude();
  end
endmodule : tb_top

`default_nettype wire
